// ===== logic/asc_sram_host.v
// host controller that drives an async byte-wide ecc sram through its pins
`timescale 1ns/100ps
`default_nettype none
`include "asc_consts.vh"

module asc_sram_host #(
    parameter AW = `ASC_ADDR_W,
    parameter DW = `ASC_DATA_W
) (
    // clock and reset
    input  wire          clk,
    input  wire          nrst,
    // user request
    input  wire          reqValid,
    input  wire          reqWrite,
    input  wire [AW-1:0] reqAddr,
    input  wire [DW-1:0] reqWdata,
    input  wire          supplyOk,
    output wire          reqReady,
    // user answer
    output reg           rspValid_ff,
    output reg  [DW-1:0] rspRdata_ff,
    output reg           rspCorrected_ff,
    // memory pins
    output reg  [AW-1:0] memAddr_ff,
    output reg           memSelectN_ff,
    output reg           memSelectP_ff,
    output reg           memWrStrobeN_ff,
    output reg           memOutStrobeN_ff,
    output reg  [DW-1:0] memDataOut_ff,
    output reg           memDataOe_ff,
    input  wire [DW-1:0] memDataIn,
    input  wire          memErrIn
);
    // ------------------------------------------------------------
    // timing counts in clocks
    // ------------------------------------------------------------
    // counts worked out wide, then cut to the counter width on purpose
    localparam integer RD_CYC_N   = `ASC_CYC(`ASC_ADDR_TO_RD_VALID_NS);
    localparam integer WR_PULSE_N = `ASC_CYC(`ASC_WR_TO_OUT_OFF_NS + `ASC_WDATA_SETUP_NS);
    localparam integer WR_CYC_N   = `ASC_CYC(`ASC_WRITE_CYCLE_MIN_NS);
    localparam integer REC_CYC_N  = `ASC_CYC(`ASC_RETENTION_REC_NS);
    localparam [3:0]   RD_CYC     = RD_CYC_N[3:0];
    localparam [3:0]   WR_PULSE   = WR_PULSE_N[3:0];
    localparam [3:0]   WR_CYC     = WR_CYC_N[3:0];
    localparam [3:0]   REC_CYC    = REC_CYC_N[3:0];

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [2:0] S_RECOVER = 3'h0;
    localparam [2:0] S_IDLE    = 3'h1;
    localparam [2:0] S_READ    = 3'h2;
    localparam [2:0] S_WRITE   = 3'h3;
    localparam [2:0] S_WREND   = 3'h4;

    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    reg        load;
    reg  [3:0] loadVal;
    wire       done;
    reg        recPend_ff;
    reg        nxt_recPend;

    asc_cnt #(.W(4)) uCnt (
        .clk     (clk),
        .nrst    (nrst),
        .load    (load),
        .loadVal (loadVal),
        .done    (done)
    );

    assign reqReady = (state_ff == S_IDLE) && supplyOk && !recPend_ff;

    // ------------------------------------------------------------
    // recovery owed after reset or any supply dip
    // ------------------------------------------------------------
    // a dip in mid-access is remembered, so idle cannot skip the wait
    always @*
    begin
        nxt_recPend = (state_ff != S_RECOVER) && (recPend_ff || !supplyOk);
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always @*
    begin
        nxt_state = state_ff;
        load      = 1'b0;
        loadVal   = 4'h0;
        case (state_ff)
            S_RECOVER:
            begin
                // supply dip or an owed wait restarts the recovery count
                if (!supplyOk || recPend_ff)
                begin
                    load    = 1'b1;
                    loadVal = REC_CYC;
                end
                else if (done)
                    nxt_state = S_IDLE;
            end
            S_IDLE:
            begin
                if (!supplyOk || recPend_ff)
                begin
                    nxt_state = S_RECOVER;
                    load      = 1'b1;
                    loadVal   = REC_CYC;
                end
                else if (reqValid)
                begin
                    nxt_state = reqWrite ? S_WRITE : S_READ;
                    load      = 1'b1;
                    loadVal   = reqWrite ? WR_PULSE : RD_CYC;
                end
            end
            S_READ:
                if (done)
                    nxt_state = S_IDLE;
            S_WRITE:
                if (done)
                begin
                    nxt_state = S_WREND;
                    load      = 1'b1;
                    loadVal   = WR_CYC - WR_PULSE;
                end
            S_WREND:
                if (done)
                    nxt_state = S_IDLE;
            default:
                nxt_state = S_RECOVER;
        endcase
    end

    // ------------------------------------------------------------
    // pins and answer
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_ff         <= S_RECOVER;
            recPend_ff       <= 1'b1;
            memAddr_ff       <= {AW{1'b0}};
            memSelectN_ff    <= 1'b1;
            memSelectP_ff    <= 1'b0;
            memWrStrobeN_ff  <= 1'b1;
            memOutStrobeN_ff <= 1'b1;
            memDataOut_ff    <= {DW{1'b0}};
            memDataOe_ff     <= 1'b0;
            rspValid_ff      <= 1'b0;
            rspRdata_ff      <= {DW{1'b0}};
            rspCorrected_ff  <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            recPend_ff  <= nxt_recPend;
            rspValid_ff <= 1'b0;
            case (state_ff)
                S_IDLE:
                    if (reqReady && reqValid)
                    begin
                        // address, data and selects move together with strobe
                        memAddr_ff       <= reqAddr;
                        memSelectN_ff    <= 1'b0;
                        memSelectP_ff    <= 1'b1;
                        memWrStrobeN_ff  <= ~reqWrite;
                        memOutStrobeN_ff <= reqWrite;
                        memDataOut_ff    <= reqWdata;
                        memDataOe_ff     <= reqWrite;
                    end
                S_READ:
                    if (done)
                    begin
                        // sampled after the longest valid delay, so old-data hold is moot
                        rspRdata_ff      <= memDataIn;
                        rspCorrected_ff  <= memErrIn;
                        rspValid_ff      <= 1'b1;
                        memSelectN_ff    <= 1'b1;
                        memSelectP_ff    <= 1'b0;
                        memOutStrobeN_ff <= 1'b1;
                    end
                S_WRITE:
                    if (done)
                    begin
                        // strobe alone ends the write; selects drop a cycle later
                        memWrStrobeN_ff <= 1'b1;
                        memDataOe_ff    <= 1'b0;
                        rspValid_ff     <= 1'b1;
                    end
                S_WREND:
                begin
                    memSelectN_ff <= 1'b1;
                    memSelectP_ff <= 1'b0;
                end
                default:
                begin
                    memWrStrobeN_ff <= 1'b1;
                end
            endcase
        end
    end
endmodule // asc_sram_host
`default_nettype wire

// ===== logic/asc_consts.vh
// timing constants and bus widths for the async ecc sram host controller
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH
`define ASC_CLK_PERIOD_NS        10
`define ASC_ADDR_W               20
`define ASC_DATA_W               8
`define ASC_READ_CYCLE_MIN_NS    45
`define ASC_ADDR_TO_RD_VALID_NS  45
`define ASC_SEL_TO_RD_VALID_NS   45
`define ASC_OUTSTROBE_VALID_NS   22
`define ASC_WRITE_CYCLE_MIN_NS   45
`define ASC_ADDR_SETUP_WEND_NS   35
`define ASC_WRITE_PULSE_MIN_NS   35
`define ASC_WDATA_SETUP_NS       25
`define ASC_WR_TO_OUT_OFF_NS     18
`define ASC_RETENTION_REC_NS     45
// least times round up to whole cycles
`define ASC_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`endif

// ===== logic/asc_cnt.v
// down counter that times one phase of an sram access
`timescale 1ns/100ps
`default_nettype none
module asc_cnt #(
    parameter W = 4
) (
    // clock and reset
    input  wire         clk,
    input  wire         nrst,
    // control
    input  wire         load,
    input  wire [W-1:0] loadVal,
    // status
    output wire         done
);
    reg  [W-1:0] cnt_ff;
    wire [W-1:0] nxt_cnt;

    assign nxt_cnt = load ? loadVal : ((cnt_ff != {W{1'b0}}) ? cnt_ff - {{(W-1){1'b0}}, 1'b1}
                                                              : cnt_ff);
    assign done    = (cnt_ff == {W{1'b0}});

    always @(posedge clk)
    begin
        if (!nrst)
            cnt_ff <= {W{1'b0}};
        else
            cnt_ff <= nxt_cnt;
    end
endmodule // asc_cnt
`default_nettype wire

// ===== dv/asc_host_props.sv
// pin sequencing checker for the sram host controller
`timescale 1ns/100ps
`default_nettype none
module asc_host_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // user side
    input wire logic        supplyOk,
    input wire logic        reqReady,
    input wire logic        rspValid_ff,
    // memory pins
    input wire logic [19:0] memAddr_ff,
    input wire logic        memSelectN_ff,
    input wire logic        memSelectP_ff,
    input wire logic        memWrStrobeN_ff,
    input wire logic        memOutStrobeN_ff,
    input wire logic [7:0]  memDataOut_ff,
    input wire logic        memDataOe_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_rdwait;
        (!memOutStrobeN_ff && !rspValid_ff) [*6] ##1 rspValid_ff;
    endsequence
    sequence s_wrhold;
        !memWrStrobeN_ff && $past(!memWrStrobeN_ff);
    endsequence
    property p_win; !memWrStrobeN_ff |-> !memSelectN_ff && memSelectP_ff; endproperty
    property p_pulse; $fell(memWrStrobeN_ff) |-> !memWrStrobeN_ff [*5]; endproperty
    property p_wend; $rose(memWrStrobeN_ff) |-> !memSelectN_ff && rspValid_ff; endproperty
    property p_data; s_wrhold |-> $stable(memDataOut_ff) && memDataOe_ff; endproperty
    property p_addr; s_wrhold |-> $stable(memAddr_ff); endproperty
    property p_oe; memDataOe_ff |-> memOutStrobeN_ff && !memWrStrobeN_ff; endproperty
    property p_rd; $fell(memOutStrobeN_ff) |-> s_rdwait; endproperty
    property p_cyc; $fell(memSelectN_ff) |-> !memSelectN_ff [*5]; endproperty
    property p_rec; $rose(nrst) |-> !reqReady [*3]; endproperty
    property p_sup; !supplyOk |=> !reqReady [*5]; endproperty
    a_win: assert property (p_win) else $error("strobe low while deselected");
    a_pulse: assert property (p_pulse) else $error("write pulse short");
    a_wend: assert property (p_wend) else $error("selects gone at write end");
    a_data: assert property (p_data) else $error("write data moved");
    a_addr: assert property (p_addr) else $error("address moved in write");
    a_oe: assert property (p_oe) else $error("data driven outside write");
    a_rd: assert property (p_rd) else $error("read sampled early");
    a_cyc: assert property (p_cyc) else $error("access cycle short");
    a_rec: assert property (p_rec) else $error("access before recovery");
    a_sup: assert property (p_sup) else $error("ready too soon after supply dip");
endmodule // asc_host_props
`default_nettype wire

// ===== dv/asc_sram_model.sv
// behavioural model of the ecc sram pins
`timescale 1ns/100ps
`default_nettype none
module asc_sram_model (
    // control pins
    input wire logic        selN,
    input wire logic        selP,
    input wire logic        wrN,
    input wire logic        outN,
    // address and data
    input wire logic [19:0] a,
    input wire logic [7:0]  din,
    output var logic [7:0]  dOut,
    output var logic        eOut
);
    // small array, upper address bits alias
    logic [7:0] mem [1024];
    wire sel = !selN && selP;
    wire win = sel && !wrN;
    wire rd = sel && wrN && !outN;
    initial
    begin
        dOut = 8'h5a;
        eOut = 1'b0;
    end
    always @(negedge win) mem[a[9:0]] = din;
    // flipped after hold so an early sample is caught
    always @(rd or a)
    begin
        #10;
        dOut = ~dOut;
        eOut = ~eOut;
        #10;
        if (rd)
        begin
            dOut = mem[a[9:0]];
            eOut = a[1];
        end
    end
endmodule // asc_sram_model
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the sram host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct packed {logic w; logic [19:0] a; logic [7:0] d; logic c;} asc_row_t;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        reqValid = 1'b0;
    logic        reqWrite = 1'b0;
    logic [19:0] reqAddr = 20'h00000;
    logic [7:0]  reqWdata = 8'h00;
    logic        supplyOk = 1'b1;
    wire         reqReady, rspValid_ff, rspCorrected_ff, memSelectN_ff, memSelectP_ff;
    wire         memWrStrobeN_ff, memOutStrobeN_ff, memDataOe_ff, memErrIn;
    wire [7:0]   rspRdata_ff, memDataOut_ff, memDataIn;
    wire [19:0]  memAddr_ff;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n;
    asc_row_t    rows [6] = '{'{1, 20'h00001, 8'ha5, 0}, '{1, 20'hfffff, 8'h3c, 0},
        '{1, 20'h00002, 8'h00, 0}, '{0, 20'h00001, 8'ha5, 0},
        '{0, 20'hfffff, 8'h3c, 1}, '{0, 20'h00002, 8'h00, 1}};
    asc_sram_host dut (.clk(clk), .nrst(nrst), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqWdata(reqWdata), .supplyOk(supplyOk), .reqReady(reqReady),
        .rspValid_ff(rspValid_ff), .rspRdata_ff(rspRdata_ff), .rspCorrected_ff(rspCorrected_ff),
        .memAddr_ff(memAddr_ff), .memSelectN_ff(memSelectN_ff), .memSelectP_ff(memSelectP_ff),
        .memWrStrobeN_ff(memWrStrobeN_ff), .memOutStrobeN_ff(memOutStrobeN_ff),
        .memDataOut_ff(memDataOut_ff), .memDataOe_ff(memDataOe_ff), .memDataIn(memDataIn),
        .memErrIn(memErrIn));
    asc_sram_model mem (.selN(memSelectN_ff), .selP(memSelectP_ff), .wrN(memWrStrobeN_ff),
        .outN(memOutStrobeN_ff), .a(memAddr_ff), .din(memDataOut_ff), .dOut(memDataIn),
        .eOut(memErrIn));
    always #5 clk = ~clk;
    task check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // n counts cycles spent waiting for ready
    task wait_ready;
        n = 0;
        @(negedge clk);
        while (reqReady !== 1'b1)
        begin
            n++;
            @(negedge clk);
        end
    endtask
    task take_rsp;
        wait_ready;
        @(posedge clk);
        reqValid <= 1'b0;
        @(negedge clk);
        while (rspValid_ff !== 1'b1) @(negedge clk);
    endtask
    task drive(input asc_row_t r);
        reqValid <= 1'b1;
        reqWrite <= r.w;
        reqAddr <= r.a;
        reqWdata <= r.d;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            stop_test;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clk);
            drive(rows[i]);
            take_rsp;
            if (!rows[i].w)
            begin
                check(rspRdata_ff, rows[i].d);
                check({7'h00, rspCorrected_ff}, {7'h00, rows[i].c});
            end
        end
        $display("rows test done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({memSelectN_ff, memSelectP_ff, memWrStrobeN_ff, memOutStrobeN_ff}, 8'h0b);
        check({memDataOe_ff, reqReady}, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        wait_ready;
        check({7'h00, n >= 5}, 8'h01);
        $display("reset test done");
        // request held while supply is low must not start
        @(posedge clk);
        supplyOk <= 1'b0;
        drive(rows[4]);
        repeat (3) @(negedge clk);
        check({memSelectN_ff, reqReady}, 8'h02);
        @(posedge clk);
        supplyOk <= 1'b1;
        take_rsp;
        check({7'h00, n >= 5}, 8'h01);
        check(rspRdata_ff, 8'h3c);
        check({7'h00, rspCorrected_ff}, 8'h01);
        $display("supply test done");
        stop_test;
    end
endmodule // tb_top
bind asc_sram_host asc_host_props u_props (.clk(clk), .nrst(nrst), .supplyOk(supplyOk),
    .reqReady(reqReady), .rspValid_ff(rspValid_ff), .memAddr_ff(memAddr_ff),
    .memSelectN_ff(memSelectN_ff), .memSelectP_ff(memSelectP_ff),
    .memWrStrobeN_ff(memWrStrobeN_ff), .memOutStrobeN_ff(memOutStrobeN_ff),
    .memDataOut_ff(memDataOut_ff), .memDataOe_ff(memDataOe_ff));
`default_nettype wire
